// >>> src/ssl_top.sv
// Supply status and level register bank with APB slave and interrupt
//
// Operation
// - Bit 24 shows oscillator stable
// - Bit 19 shows PLL rail good
// - Bit 16 shows core rail good
// - Bits 9/8 show buck current limiting
// - Bits 1/0 show buck soft-start
// - Writable 7-bit core code, 10 mV steps
// - Writable 3-bit PLL code, 100 mV steps
// - Level codes reset from strap pins
//
// Design decision made here: the APB interface to the registers.
module ssl_top (
	input wire logic core_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Live supply conditions from analogue
	input wire logic oscStable,
	input wire logic pllRailGood,
	input wire logic coreRailGood,
	input wire logic analogLimit,
	input wire logic coreLimit,
	input wire logic analogSoftStart,
	input wire logic coreSoftStart,
	// Mode strap pins
	input wire logic [6:0] coreLevelStrap,
	input wire logic [2:0] pllLevelStrap,
	// Level codes to regulators
	output logic [6:0] coreSupplyRailCode,
	output logic [2:0] pllLinearRegulatorCode,
	// Interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisation of raw conditions

	ssl_sync_if syncBus (); // Synchronised conditions and edges
	logic [ssl_pkg::COND_COUNT-1:0] rawCond; // Packed raw inputs
	logic [ssl_pkg::COND_COUNT-1:0] strapCore; // Core strap pins, fed to the strap synchroniser
	logic [ssl_pkg::COND_COUNT-1:0] strapSync1_q; // Core strap stage one
	logic [ssl_pkg::COND_COUNT-1:0] strapSync2_q; // Core strap stage two
	logic [2:0] pllStrapSync1_q; // PLL strap stage one
	logic [2:0] pllStrapSync2_q; // PLL strap stage two

	// Pack inputs in a fixed order
	assign rawCond = {oscStable, pllRailGood, coreRailGood, analogLimit,
		coreLimit, analogSoftStart, coreSoftStart};
	assign strapCore = coreLevelStrap;

	ssl_cond_sync uSync (
		.core_clk(core_clk),
		.rst(rst),
		.rawCond(rawCond),
		.syncBus(syncBus)
	);

	// Straps are pins too, so they are synchronised before loading
	always_ff @(posedge core_clk) begin
		strapSync1_q <= strapCore;
		strapSync2_q <= strapSync1_q;
		pllStrapSync1_q <= pllLevelStrap;
		pllStrapSync2_q <= pllStrapSync1_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Status word assembly from live conditions

	logic [31:0] statusWord; // Read value of status register
	wire sOsc = syncBus.cond[6];
	wire sPll = syncBus.cond[5];
	wire sCore = syncBus.cond[4];
	wire sAnaLim = syncBus.cond[3];
	wire sCoreLim = syncBus.cond[2];
	wire sAnaSoft = syncBus.cond[1];
	wire sCoreSoft = syncBus.cond[0];

	// Reserved positions stay zero; every bit is live, never latched
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[ssl_pkg::OSC_STABLE_BIT] = sOsc;
		statusWord[ssl_pkg::PLL_GOOD_BIT] = sPll;
		statusWord[ssl_pkg::CORE_GOOD_BIT] = sCore;
		statusWord[ssl_pkg::ANALOG_LIMIT_BIT] = sAnaLim;
		statusWord[ssl_pkg::CORE_LIMIT_BIT] = sCoreLim;
		statusWord[ssl_pkg::ANALOG_SOFT_BIT] = sAnaSoft;
		statusWord[ssl_pkg::CORE_SOFT_BIT] = sCoreSoft;
	end

	////////////////////////////////////////////////////////////////////////
	// APB decode

	wire apbAccess = psel & penable; // Access phase, answered one cycle later
	wire apbWrite = apbAccess & pwrite;
	wire hitStatus = (paddr == ssl_pkg::STATUS_OFFSET);
	wire hitCore = (paddr == ssl_pkg::CORE_LEVEL_OFFSET);
	wire hitPll = (paddr == ssl_pkg::PLL_LEVEL_OFFSET);
	wire hitIrqSt = (paddr == ssl_pkg::IRQ_STATUS_OFFSET);
	wire hitIrqMask = (paddr == ssl_pkg::IRQ_MASK_OFFSET);
	wire hitAny = hitStatus | hitCore | hitPll | hitIrqSt | hitIrqMask;
	// Status register has no write path at all
	wire coreWrEn = apbWrite & hitCore;
	wire pllWrEn = apbWrite & hitPll;
	wire irqStWr = apbWrite & hitIrqSt;
	wire irqMaskWr = apbWrite & hitIrqMask;

	////////////////////////////////////////////////////////////////////////
	// Level code registers

	logic [6:0] coreCode_q; // Core rail code
	logic [2:0] pllCode_q; // PLL regulator code

	ssl_level_regs uLevels (
		.core_clk(core_clk),
		.rst(rst),
		.coreStrap(strapSync2_q),
		.pllStrap(pllStrapSync2_q),
		.coreWrEn(coreWrEn),
		.pllWrEn(pllWrEn),
		.wrData(pwdata),
		.coreCode_q(coreCode_q),
		.pllCode_q(pllCode_q)
	);

	// Regulator outputs come straight from the code flops
	assign coreSupplyRailCode = coreCode_q;
	assign pllLinearRegulatorCode = pllCode_q;

	////////////////////////////////////////////////////////////////////////
	// Interrupt events: sticky, write one to clear, set wins

	logic [ssl_pkg::EVT_COUNT-1:0] irqStatus_q; // Sticky event bits
	logic [ssl_pkg::EVT_COUNT-1:0] irqStatus_d;
	logic [ssl_pkg::EVT_COUNT-1:0] irqMask_q; // One enables the event
	logic [ssl_pkg::EVT_COUNT-1:0] evtSet; // Event pulses
	logic [ssl_pkg::EVT_COUNT-1:0] evtClr; // Software clear strobes

	assign evtSet[ssl_pkg::EVT_OSC_STABLE] = syncBus.rise[6];
	assign evtSet[ssl_pkg::EVT_PLL_GOOD_LOST] = syncBus.fall[5];
	assign evtSet[ssl_pkg::EVT_CORE_GOOD_LOST] = syncBus.fall[4];
	// Either buck entering current limit
	assign evtSet[ssl_pkg::EVT_LIMIT] = syncBus.rise[3] | syncBus.rise[2];
	assign evtClr = irqStWr ? pwdata[ssl_pkg::EVT_COUNT-1:0] : '0;
	// A set in the clearing cycle survives the clear
	assign irqStatus_d = (irqStatus_q & ~evtClr) | evtSet;

	// Status and mask registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irqStatus_q <= '0;
			irqMask_q <= '0;
		end else begin
			irqStatus_q <= irqStatus_d;
			if (irqMaskWr) begin
				irqMask_q <= pwdata[ssl_pkg::EVT_COUNT-1:0];
			end
		end
	end

	// Registered level interrupt
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStatus_d & irqMask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; reserved bits read zero

	logic [31:0] rdMux; // Selected read word
	always_comb begin
		rdMux = ssl_pkg::UNMAPPED_DATA;
		if (hitStatus) begin
			rdMux = statusWord;
		end else if (hitCore) begin
			rdMux = {25'h000_0000, coreCode_q};
		end else if (hitPll) begin
			rdMux = {29'h0000_0000, pllCode_q};
		end else if (hitIrqSt) begin
			rdMux = {28'h000_0000, irqStatus_q};
		end else if (hitIrqMask) begin
			rdMux = {28'h000_0000, irqMask_q};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB answer: pready one cycle after access phase starts, so every
	// output is a flop; a completed access drops pready for one cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= apbAccess & ~pready;
			prdata <= (apbAccess & ~pwrite & ~pready) ? rdMux : 32'h0000_0000;
			pslverr <= apbAccess & ~pready & ~hitAny;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Assertions

	AST_OSC_BIT: assert property (@(posedge core_clk) disable iff (rst)
		statusWord[ssl_pkg::OSC_STABLE_BIT] == $past(oscStable, 2))
		else $error("Oscillator status bit wrong");

	AST_PLL_BIT: assert property (@(posedge core_clk) disable iff (rst)
		$rose(pllRailGood) |-> ##3 statusWord[19])
		else $error("PLL good not seen after sync delay");

	AST_CORE_BIT: assert property (@(posedge core_clk) disable iff (rst)
		$fell(coreRailGood) |-> ##3 !statusWord[16])
		else $error("Core good not cleared after sync delay");

	AST_LIMIT_BITS: assert property (@(posedge core_clk) disable iff (rst)
		statusWord[9:8] == $past({analogLimit, coreLimit}, 2))
		else $error("Current limit bits wrong");

	AST_SOFT_BITS: assert property (@(posedge core_clk) disable iff (rst)
		statusWord[1:0] == $past(rawCond[1:0], 2))
		else $error("Soft-start bits do not track inputs");

	sequence coreWrite_s;
		apbWrite && hitCore && !pready;
	endsequence

	AST_CORE_WRITE: assert property (@(posedge core_clk) disable iff (rst)
		coreWrite_s ##1 !$past(rst, 2) |-> coreCode_q == $past(pwdata[6:0]))
		else $error("Core code not written");

	AST_PLL_HOLD: assert property (@(posedge core_clk) disable iff (rst)
		!(pllWrEn) && !$past(rst) |=> $stable(pllCode_q))
		else $error("PLL code changed without write");

	AST_STRAP_LOAD: assert property (@(posedge core_clk)
		$fell(rst) |=> coreCode_q == $past(strapSync2_q)
		&& pllCode_q == $past(pllStrapSync2_q))
		else $error("Level codes not loaded from straps");

	AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (rst)
		pready && !pslverr && $past(hitCore) && !$past(pwrite)
		|-> prdata[31:7] == 25'h000_0000)
		else $error("Reserved bits read nonzero");

endmodule

// >>> src/ssl_pkg.sv
// Package of register map, field layout, code widths and event bits for the block
package ssl_pkg;

	// Register byte offsets
	localparam logic [7:0] STATUS_OFFSET = 8'h30;
	localparam logic [7:0] CORE_LEVEL_OFFSET = 8'h34;
	localparam logic [7:0] PLL_LEVEL_OFFSET = 8'h40;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h50;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h54;

	// Status word field positions
	localparam int OSC_STABLE_BIT = 24;
	localparam int PLL_GOOD_BIT = 19;
	localparam int CORE_GOOD_BIT = 16;
	localparam int ANALOG_LIMIT_BIT = 9;
	localparam int CORE_LIMIT_BIT = 8;
	localparam int ANALOG_SOFT_BIT = 1;
	localparam int CORE_SOFT_BIT = 0;

	// Number of supply condition inputs
	localparam int COND_COUNT = 7;

	// Level code widths
	localparam int CORE_CODE_WIDTH = 7;
	localparam int PLL_CODE_WIDTH = 3;

	// Largest meaningful core code (1.30 V)
	localparam logic [6:0] CORE_CODE_MAX = 7'h46;

	// Interrupt event bits in the irq status and mask registers
	localparam int EVT_OSC_STABLE = 0;
	localparam int EVT_PLL_GOOD_LOST = 1;
	localparam int EVT_CORE_GOOD_LOST = 2;
	localparam int EVT_LIMIT = 3;
	localparam int EVT_COUNT = 4;

	// Read-back value for unmapped addresses
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage

// >>> src/ssl_sync_if.sv
// Interface carrying synchronised supply conditions between modules
interface ssl_sync_if;
	logic [ssl_pkg::COND_COUNT-1:0] cond; // Synchronised condition levels
	logic [ssl_pkg::COND_COUNT-1:0] rise; // One-cycle rising pulses
	logic [ssl_pkg::COND_COUNT-1:0] fall; // One-cycle falling pulses

	modport producer (output cond, output rise, output fall);
	modport consumer (input cond, input rise, input fall);
endinterface

// >>> src/ssl_cond_sync.sv
// Two-flop synchronisers and edge detect for supply condition inputs
module ssl_cond_sync (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [ssl_pkg::COND_COUNT-1:0] rawCond,
	ssl_sync_if.producer syncBus
);

	////////////////////////////////////////////////////////////////////////
	// Per-bit synchroniser; stage one is read only by stage two
	genvar i;
	generate
		for (i = 0; i < ssl_pkg::COND_COUNT; i++) begin : gSync
			logic meta_q; // First stage
			logic sync_q; // Second stage
			logic prev_q; // Delayed copy for edge detect

			// Chain of three flops, cleared by reset
			always_ff @(posedge core_clk) begin
				if (rst) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
					prev_q <= 1'b0;
				end else begin
					meta_q <= rawCond[i];
					sync_q <= meta_q;
					prev_q <= sync_q;
				end
			end

			// Edge pulses derive from settled stages only
			assign syncBus.cond[i] = sync_q;
			assign syncBus.rise[i] = sync_q & ~prev_q;
			assign syncBus.fall[i] = ~sync_q & prev_q;
		end
	endgenerate

endmodule

// >>> src/ssl_level_regs.sv
// Strap-loaded voltage level code registers
module ssl_level_regs (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [6:0] coreStrap,
	input wire logic [2:0] pllStrap,
	input wire logic coreWrEn,
	input wire logic pllWrEn,
	input wire logic [31:0] wrData,
	output logic [6:0] coreCode_q,
	output logic [2:0] pllCode_q
);

	logic loadPend_q; // High in the first cycle after reset release

	////////////////////////////////////////////////////////////////////////
	// Straps are caught by the clocked process after reset, never as a
	// reset constant, so level codes follow the mode pins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			loadPend_q <= 1'b1;
			coreCode_q <= 7'h00;
			pllCode_q <= 3'h0;
		end else if (loadPend_q) begin
			loadPend_q <= 1'b0;
			coreCode_q <= coreStrap;
			pllCode_q <= pllStrap;
		end else begin
			// Only the low field bits are stored
			if (coreWrEn) begin
				coreCode_q <= wrData[ssl_pkg::CORE_CODE_WIDTH-1:0];
			end
			if (pllWrEn) begin
				pllCode_q <= wrData[ssl_pkg::PLL_CODE_WIDTH-1:0];
			end
		end
	end

endmodule

// >>> sim/tb.sv
// Self-checking bench for the supply status and level register bank
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk; // 25 MHz core clock
	logic rst; // Synchronous active-high reset
	logic psel, penable, pwrite; // APB request
	logic [7:0] paddr; // APB byte address
	logic [31:0] pwdata, prdata; // APB data
	logic pready, pslverr; // APB answer
	logic [6:0] cond; // Live conditions, osc first, core soft-start last
	logic [6:0] coreSupplyRailCode; // Core code to regulator
	logic [2:0] pllLinearRegulatorCode; // PLL code to regulator
	logic irq; // Level interrupt
	logic [31:0] rd; // Last read data
	logic err, irqA; // Last error flag, irq under first mask
	int mismatches = 0; // Failed comparisons
	int comparisons = 0; // All comparisons
	int cycles = 0; // Cycle count for the hang guard
	int bitPos [7] = '{ssl_pkg::OSC_STABLE_BIT, ssl_pkg::PLL_GOOD_BIT,
		ssl_pkg::CORE_GOOD_BIT, ssl_pkg::ANALOG_LIMIT_BIT,
		ssl_pkg::CORE_LIMIT_BIT, ssl_pkg::ANALOG_SOFT_BIT,
		ssl_pkg::CORE_SOFT_BIT}; // Status bit of each condition

	ssl_top i_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .oscStable(cond[0]), .pllRailGood(cond[1]),
		.coreRailGood(cond[2]), .analogLimit(cond[3]),
		.coreLimit(cond[4]), .analogSoftStart(cond[5]),
		.coreSoftStart(cond[6]), .coreLevelStrap(7'h2A),
		.pllLevelStrap(3'h5), .coreSupplyRailCode(coreSupplyRailCode),
		.pllLinearRegulatorCode(pllLinearRegulatorCode), .irq(irq));

	////////////////////////////////////////////////////////////////////////
	// Clock, and a guard that ends a hung run
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		// Whole run needs just under a thousand cycles
		if (cycles == 3000) begin
			mismatches++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Closing report
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Word comparison
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Single-bit comparison
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer; idle cycle before setup so psel is never
	// assigned twice in one time step
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Wait for the answer, sampled at the edge itself
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read with expected data and no error
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk32(rd, exp);
		chk1(err, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		cond = 7'h00;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		// Codes come from the straps after reset
		chk32(32'(coreSupplyRailCode), 32'h0000_002A);
		chk32(32'(pllLinearRegulatorCode), 32'h0000_0005);
		rdChk(ssl_pkg::CORE_LEVEL_OFFSET, 32'h0000_002A);
		rdChk(ssl_pkg::PLL_LEVEL_OFFSET, 32'h0000_0005);
		// Walk one condition at a time through the status word
		for (int i = 0; i < 7; i++) begin
			cond <= 7'h01 << i;
			repeat (4) @(posedge core_clk);
			rdChk(ssl_pkg::STATUS_OFFSET, 32'h1 << bitPos[i]);
		end
		// Status ignores writes and stays live
		cond <= 7'h7F;
		apb(1'b1, ssl_pkg::STATUS_OFFSET, 32'h0000_0000);
		rdChk(ssl_pkg::STATUS_OFFSET, 32'h0109_0303);
		// Core code ramps one 10 mV step every 29 cycles (25-cycle wait, then the write),
		// reserved bits set in every write must be dropped
		for (int v = 32'h0000_002B; v <= 32'h0000_0046; v++) begin
			repeat (25) @(posedge core_clk);
			apb(1'b1, ssl_pkg::CORE_LEVEL_OFFSET, 32'hFFFF_FF80 | 32'(v));
		end
		rdChk(ssl_pkg::CORE_LEVEL_OFFSET, 32'h0000_0046);
		chk32(32'(coreSupplyRailCode), 32'h0000_0046);
		repeat (25) @(posedge core_clk);
		apb(1'b1, ssl_pkg::CORE_LEVEL_OFFSET, 32'h0000_0045);
		rdChk(ssl_pkg::CORE_LEVEL_OFFSET, 32'h0000_0045);
		// PLL code is raised one step per write from its strap value
		apb(1'b1, ssl_pkg::PLL_LEVEL_OFFSET, 32'hFFFF_FFF6);
		apb(1'b1, ssl_pkg::PLL_LEVEL_OFFSET, 32'hFFFF_FFF7);
		rdChk(ssl_pkg::PLL_LEVEL_OFFSET, 32'h0000_0007);
		chk32(32'(pllLinearRegulatorCode), 32'h0000_0007);
		// Unmapped address answers with an error and zero data
		apb(1'b0, 8'h3C, 32'h0000_0000);
		chk32(rd, ssl_pkg::UNMAPPED_DATA);
		chk1(err, 1'b1);
		// Interrupt: settle rails good, clear, then fire all four events
		cond <= 7'h06;
		repeat (5) @(posedge core_clk);
		apb(1'b1, ssl_pkg::IRQ_STATUS_OFFSET, 32'h0000_000F);
		rdChk(ssl_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000);
		chk1(irq, 1'b0);
		apb(1'b1, ssl_pkg::IRQ_MASK_OFFSET, 32'h0000_0000);
		cond <= 7'h09;
		repeat (5) @(posedge core_clk);
		apb(1'b0, ssl_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000);
		chk32(32'(rd[3:0]), 32'h0000_000F);
		irqA = irq;
		// Opposite mask must flip the interrupt line
		apb(1'b1, ssl_pkg::IRQ_MASK_OFFSET, 32'h0000_000F);
		repeat (3) @(posedge core_clk);
		chk1(irqA ^ irq, 1'b1);
		// Write-one-to-clear leaves the other bits alone
		apb(1'b1, ssl_pkg::IRQ_STATUS_OFFSET, 32'h0000_0005);
		apb(1'b0, ssl_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000);
		chk32(32'(rd[3:0]), 32'h0000_000A);
		apb(1'b1, ssl_pkg::IRQ_STATUS_OFFSET, 32'h0000_000A);
		repeat (3) @(posedge core_clk);
		chk1(irq, 1'b0);
		test_done();
	end
endmodule
